// ==== hdl/omc_regs.svh ====
// Constants of the output margin command register bank.
// Assumes the includer wants plain `define macros; no logic lives here.
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// Command codes
`define OMC_CODE_STORE_ALL     8'h11
`define OMC_CODE_RESTORE_ALL   8'h12
`define OMC_CODE_STORE_ONE     8'h13
`define OMC_CODE_RESTORE_ONE   8'h14
`define OMC_CODE_MODE          8'h20
`define OMC_CODE_MARGIN_HIGH   8'h25
`define OMC_CODE_MARGIN_LOW    8'h26
`define OMC_CODE_SCALE         8'h29

// Reset values and fixed fields
`define OMC_RST_MARGIN_HIGH    16'h0547
`define OMC_RST_MARGIN_LOW     16'h0451
`define OMC_RST_SCALE_MANT     10'h100
`define OMC_SCALE_MANT_MAX     10'h200
`define OMC_SCALE_MANT_MIN     10'h001
`define OMC_SCALE_EXP_FIELD    6'h2E
`define OMC_MODE_VALUE         16'h0016

// Limit arithmetic: reference in mV, output LSB 2^-10, scale LSB 2^-9
`define OMC_VREF_MV            32'h0000_0258
`define OMC_LSB_PER_V          32'h0000_0400
`define OMC_MANT_PER_UNIT      32'h0000_0200
`define OMC_MV_PER_V_X4        32'h0000_0FA0
`define OMC_MULT_HIGH          32'h0000_0005
`define OMC_MULT_LOW           32'h0000_0003

`endif

// ==== hdl/omc_pkg.sv ====
// Types shared by the output margin command register bank.
// Assumes the PMBus core decodes frames and hands over command words.
package omc_pkg;

  // One decoded command from the PMBus core
  typedef struct packed {
    logic        wr;    // Write word or send byte
    logic        rd;    // Read word request
    logic [7:0]  code;  // Command code
    logic [15:0] data;  // Write data; low byte carries code for single store
  } omc_cmd_t;

  // Operation request from the operation command decoder
  typedef enum logic [1:0] {
    OMC_SEL_NOMINAL = 2'b00,
    OMC_SEL_HIGH    = 2'b01,
    OMC_SEL_LOW     = 2'b10
  } omc_sel_t;

  typedef struct packed {
    logic     strobe;   // One-cycle pulse when operation is written
    omc_sel_t sel;      // Requested output state
  } omc_op_t;

  // Check sequencer
  typedef enum logic [0:0] {
    OMC_ST_IDLE  = 1'b0,
    OMC_ST_CHECK = 1'b1
  } omc_state_t;

endpackage

// ==== hdl/omc_margin_regs.sv ====
// Output margin target, feedback scale and mode registers with the
// deferred range check and clamp, plus the saved power-up image of each but the fixed mode word.
// Assumes cmd and op come from same-clock logic, so neither passes a
// synchroniser here, and trim is the live trim register word.
// Assumes the status registers that hold cml and ivd live outside and
// take ivd_pulse_ff as their set event.
`timescale 1ns/10ps
`include "omc_regs.svh"

module omc_margin_regs (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Command port from PMBus core
  input  wire omc_pkg::omc_cmd_t cmd,
  output logic           [15:0] rd_data_ff,
  output logic                  rd_ack_ff,
  output logic                  rd_hit_ff,
  // Operation request and trim offset
  input  wire omc_pkg::omc_op_t op,
  input  wire logic      [15:0] trim,
  // Commanded output and status events
  output logic           [16:0] vout_cmd_ff,
  output logic                  margin_active_ff,
  output logic                  ivd_pulse_ff,
  output logic                  clamp_high_ff,
  output logic                  clamp_low_ff
);

  // Live registers; bit 15 of each margin word is not stored and reads zero
  logic [14:0] margin_high_ff;    // Writable bits of margin high
  logic [14:0] margin_low_ff;     // Writable bits of margin low
  logic [9:0]  scale_mant_ff;     // Scale mantissa, exponent is fixed
  // Saved copies, the power-up defaults; a store overwrites, reset reloads
  logic [14:0] nv_high_ff;        // Saved margin high image
  logic [14:0] nv_low_ff;         // Saved margin low image
  logic [9:0]  nv_mant_ff;        // Saved scale mantissa image
  // Check pipeline; target and limits are frozen at the request edge
  omc_pkg::omc_state_t state_ff;  // Idle or comparing
  logic [15:0] target_ff;         // Target captured at request
  logic [15:0] lim_high_ff;       // Upper permitted target
  logic [15:0] lim_low_ff;        // Lower permitted target
  // Next values from combinational logic
  logic [15:0] nxt_target;        // Register picked by the request
  logic [15:0] nxt_setting;       // Target after the clamp
  logic        nxt_over;          // Target above upper limit
  logic        nxt_under;         // Target below lower limit
  logic [9:0]  nxt_mant;          // Scale write after coercion
  logic [16:0] nxt_vout;          // Clamped target plus trim

  // Limit in 2^-10 units from reference, scale and multiplier over four.
  // Nominal output is the reference divided by the scale, so a smaller
  // mantissa gives a higher nominal and wider limits. The largest product
  // stays below 2^31, so 32 bits hold it; a tiny mantissa can push the
  // quotient past the margin word, hence the cap at the largest positive.
  function automatic logic [15:0] lim_calc(input logic [31:0] mult,
                                           input logic [9:0]  mant);
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] q;
    num = `OMC_VREF_MV * `OMC_LSB_PER_V * `OMC_MANT_PER_UNIT * mult;
    den = `OMC_MV_PER_V_X4 * {22'h000000, mant};
    q   = num / den;
    lim_calc = (q > 32'h0000_7FFF) ? 16'h7FFF : q[15:0];
  endfunction

  // Scale write kept between one and the full ratio. A zero mantissa would
  // make the limit divider divide by zero, so it is raised to one step;
  // anything above the full ratio is pulled down to it. Bit 10 of the write,
  // the lowest exponent bit, counts in that test; the other exponent bits
  // are dropped, since they always read back fixed.
  always_comb begin
    nxt_mant = cmd.data[9:0];
    if (cmd.data[10:0] > {1'b0, `OMC_SCALE_MANT_MAX}) begin
      nxt_mant = `OMC_SCALE_MANT_MAX;
    end else if (cmd.data[9:0] == 10'h000) begin
      nxt_mant = `OMC_SCALE_MANT_MIN;  // Avoid a zero divisor
    end
  end

  // Margin high register: write, store, restore.
  // Only one command code arrives per cycle, so a write, a store and a
  // restore never meet at one edge. A write is taken whatever its value;
  // the range check waits for the next margin request. The saved image
  // changes only on a store or a reset, so a restore can be repeated safely.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      margin_high_ff <= 15'(`OMC_RST_MARGIN_HIGH);
      nv_high_ff     <= 15'(`OMC_RST_MARGIN_HIGH);
    end else if (cmd.wr) begin
      unique case (cmd.code)
        `OMC_CODE_MARGIN_HIGH: begin
          margin_high_ff <= cmd.data[14:0];  // No check here
        end
        `OMC_CODE_STORE_ALL: begin
          nv_high_ff <= margin_high_ff;
        end
        `OMC_CODE_RESTORE_ALL: begin
          margin_high_ff <= nv_high_ff;
        end
        `OMC_CODE_STORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_MARGIN_HIGH) begin
            nv_high_ff <= margin_high_ff;  // Only when the data byte names it
          end
        end
        `OMC_CODE_RESTORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_MARGIN_HIGH) begin
            margin_high_ff <= nv_high_ff;  // Only when the data byte names it
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Margin low register: write, store, restore.
  // Same scheme as margin high; a value far out of range is kept as
  // written and only clamped when a margin low request reaches the compare.
  // Bit 15 of the write word is dropped, so the stored word stays positive.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      margin_low_ff <= 15'(`OMC_RST_MARGIN_LOW);
      nv_low_ff     <= 15'(`OMC_RST_MARGIN_LOW);
    end else if (cmd.wr) begin
      unique case (cmd.code)
        `OMC_CODE_MARGIN_LOW: begin
          margin_low_ff <= cmd.data[14:0];  // No check here
        end
        `OMC_CODE_STORE_ALL: begin
          nv_low_ff <= margin_low_ff;
        end
        `OMC_CODE_RESTORE_ALL: begin
          margin_low_ff <= nv_low_ff;
        end
        `OMC_CODE_STORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_MARGIN_LOW) begin
            nv_low_ff <= margin_low_ff;  // Only when the data byte names it
          end
        end
        `OMC_CODE_RESTORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_MARGIN_LOW) begin
            margin_low_ff <= nv_low_ff;  // Only when the data byte names it
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Scale mantissa: write, store, restore.
  // The coerced value is what gets stored, so neither the live register nor
  // the saved image can hold a zero divisor or a ratio above one. A new
  // scale moves the limits only at the next margin request.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scale_mant_ff <= `OMC_RST_SCALE_MANT;  // Ratio one half
      nv_mant_ff    <= `OMC_RST_SCALE_MANT;
    end else if (cmd.wr) begin
      unique case (cmd.code)
        `OMC_CODE_SCALE: begin
          scale_mant_ff <= nxt_mant;
        end
        `OMC_CODE_STORE_ALL: begin
          nv_mant_ff <= scale_mant_ff;
        end
        `OMC_CODE_RESTORE_ALL: begin
          scale_mant_ff <= nv_mant_ff;
        end
        `OMC_CODE_STORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_SCALE) begin
            nv_mant_ff <= scale_mant_ff;  // Only when the data byte names it
          end
        end
        `OMC_CODE_RESTORE_ONE: begin
          if (cmd.data[7:0] == `OMC_CODE_SCALE) begin
            scale_mant_ff <= nv_mant_ff;  // Only when the data byte names it
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read port: answer one cycle after the request.
  // Every read is acknowledged, mapped or not, so the core never waits;
  // an unmapped code answers with hit low and data zero. Data is zero
  // whenever no answer stands, so a stale word never lingers for the
  // core to pick up by mistake.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 16'h0000;
      rd_ack_ff  <= 1'b0;
      rd_hit_ff  <= 1'b0;
    end else begin
      rd_ack_ff <= cmd.rd;
      rd_hit_ff <= 1'b0;
      rd_data_ff <= 16'h0000;
      if (cmd.rd) begin
        unique case (cmd.code)
          `OMC_CODE_MODE: begin
            rd_data_ff <= `OMC_MODE_VALUE;  // Fixed
            rd_hit_ff  <= 1'b1;
          end
          `OMC_CODE_MARGIN_HIGH: begin
            rd_data_ff <= {1'b0, margin_high_ff};
            rd_hit_ff  <= 1'b1;
          end
          `OMC_CODE_MARGIN_LOW: begin
            rd_data_ff <= {1'b0, margin_low_ff};
            rd_hit_ff  <= 1'b1;
          end
          `OMC_CODE_SCALE: begin
            rd_data_ff <= {`OMC_SCALE_EXP_FIELD, scale_mant_ff};
            rd_hit_ff  <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Target chosen by the request; the register value at the request edge
  // is the one checked, and a later write waits for the next request.
  // Any select other than low picks high; nominal never starts a check.
  always_comb begin
    nxt_target = (op.sel == omc_pkg::OMC_SEL_LOW) ? {1'b0, margin_low_ff}
                                                  : {1'b0, margin_high_ff};
  end

  // Check sequencer: capture on request, compare next cycle.
  // The divide sits between the scale register and the limit flops, so the
  // compare in the following cycle sees settled limits. A margin request
  // that lands in the compare cycle is dropped; the core spaces margin
  // requests at least two cycles apart.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= omc_pkg::OMC_ST_IDLE;
      target_ff   <= 16'h0000;
      lim_high_ff <= 16'h0000;
      lim_low_ff  <= 16'h0000;
    end else begin
      unique case (state_ff)
        omc_pkg::OMC_ST_IDLE: begin
          // Only a margin request starts a check
          if (op.strobe && (op.sel != omc_pkg::OMC_SEL_NOMINAL)) begin
            target_ff   <= nxt_target;
            // Limits from scaled nominal, trim left out
            lim_high_ff <= lim_calc(`OMC_MULT_HIGH, scale_mant_ff);
            lim_low_ff  <= lim_calc(`OMC_MULT_LOW, scale_mant_ff);
            state_ff    <= omc_pkg::OMC_ST_CHECK;
          end
        end
        omc_pkg::OMC_ST_CHECK: begin
          state_ff <= omc_pkg::OMC_ST_IDLE;
        end
      endcase
    end
  end

  // Range compare and clamp of the captured target.
  // The upper limit never lies below the lower one, so over and under are
  // never set together. Trim is added after the clamp, so it shifts the
  // output but never the verdict; the 17-bit sum cannot overflow, as both
  // terms are sign-extended from 16 bits.
  always_comb begin
    nxt_over    = target_ff > lim_high_ff;
    nxt_under   = target_ff < lim_low_ff;
    nxt_setting = target_ff;
    if (nxt_over) begin
      nxt_setting = lim_high_ff;
    end else if (nxt_under) begin
      nxt_setting = lim_low_ff;
    end
    // Margin plus trim, both in 2^-10 units
    nxt_vout = 17'({nxt_setting[15], nxt_setting} + {trim[15], trim});
  end

  // Commanded output and invalid data event.
  // A nominal request wins over a compare that ends in the same cycle,
  // since it is the later command; the commanded value then keeps its last
  // level and the clamp flags clear. The invalid data event lasts one cycle
  // and is the only thing the status registers outside need.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vout_cmd_ff      <= 17'h00000;
      margin_active_ff <= 1'b0;
      ivd_pulse_ff     <= 1'b0;
      clamp_high_ff    <= 1'b0;
      clamp_low_ff     <= 1'b0;
    end else begin
      ivd_pulse_ff <= 1'b0;
      if (op.strobe && (op.sel == omc_pkg::OMC_SEL_NOMINAL)) begin
        margin_active_ff <= 1'b0;  // Back to nominal
        clamp_high_ff    <= 1'b0;
        clamp_low_ff     <= 1'b0;
      end else if (state_ff == omc_pkg::OMC_ST_CHECK) begin
        vout_cmd_ff      <= nxt_vout;
        margin_active_ff <= 1'b1;
        ivd_pulse_ff     <= nxt_over | nxt_under;   // Sets cml and ivd
        clamp_high_ff    <= nxt_over;
        clamp_low_ff     <= nxt_under;
      end
    end
  end

endmodule

// ==== tb/omc_margin_regs_props.sv ====
// Port checker for the margin register bank.
// Assumes one clock domain; bound onto the top module.
`timescale 1ns/10ps
module omc_margin_regs_props (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Command side
  input wire omc_pkg::omc_cmd_t cmd,
  input wire logic       [15:0] rd_data_ff,
  input wire logic              rd_ack_ff,
  input wire logic              rd_hit_ff,
  // Operation side
  input wire omc_pkg::omc_op_t  op,
  input wire logic       [15:0] trim,
  input wire logic       [16:0] vout_cmd_ff,
  input wire logic              margin_active_ff,
  input wire logic              ivd_pulse_ff,
  input wire logic              clamp_high_ff,
  input wire logic              clamp_low_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_MODE_RD: assert property (
    cmd.rd && cmd.code == 8'h20 |=> rd_ack_ff && rd_hit_ff && rd_data_ff == 16'h0016)
    else $error("mode word wrong");
  AST_MARGIN_MSB: assert property (
    cmd.rd && (cmd.code == 8'h25 || cmd.code == 8'h26) |=> rd_hit_ff && !rd_data_ff[15])
    else $error("margin word top bit set");
  AST_SCALE_RD: assert property (
    cmd.rd && cmd.code == 8'h29 |=> rd_data_ff[15:10] == 6'h2E && rd_data_ff[9:0] <= 10'h200)
    else $error("scale word out of form");
  AST_ACTIVE: assert property (
    op.strobe && op.sel != omc_pkg::OMC_SEL_NOMINAL && !$past(op.strobe) |=> ##1 margin_active_ff)
    else $error("margin state not applied");
  AST_NOMINAL: assert property (
    op.strobe && op.sel == omc_pkg::OMC_SEL_NOMINAL && !$past(op.strobe)
    |=> !margin_active_ff && !clamp_high_ff && !clamp_low_ff) else $error("nominal not applied");
  AST_IVD_CAUSE: assert property (
    ivd_pulse_ff |-> $past(op.strobe, 2) && (clamp_high_ff != clamp_low_ff))
    else $error("invalid flag without request or clamp");
  AST_IVD_ONE: assert property (
    ivd_pulse_ff |=> !ivd_pulse_ff) else $error("invalid flag longer than one cycle");
  AST_VOUT_HOLD: assert property (
    !$past(op.strobe, 2) |-> $stable(vout_cmd_ff)) else $error("output moved without request");
endmodule
bind omc_margin_regs omc_margin_regs_props u_props (
  .mclk(mclk), .rst_n(rst_n), .cmd(cmd), .rd_data_ff(rd_data_ff), .rd_ack_ff(rd_ack_ff),
  .rd_hit_ff(rd_hit_ff), .op(op), .trim(trim), .vout_cmd_ff(vout_cmd_ff),
  .margin_active_ff(margin_active_ff), .ivd_pulse_ff(ivd_pulse_ff),
  .clamp_high_ff(clamp_high_ff), .clamp_low_ff(clamp_low_ff)
);

// ==== tb/omc_host_model.sv ====
// Bus host model issuing command words and operation requests.
// Assumes the bench calls its tasks; drives 1 ns after rising edges.
`timescale 1ns/10ps
module omc_host_model (
  // Clock
  input  wire logic         mclk,
  // Read answer
  input  wire logic  [15:0] rd_data_ff,
  input  wire logic         rd_ack_ff,
  input  wire logic         rd_hit_ff,
  // Requests
  output omc_pkg::omc_cmd_t cmd,
  output omc_pkg::omc_op_t  op
);
  // Idle at time zero
  initial begin
    cmd = '0;
    op = '0;
  end
  // Write word; store and restore codes travel the same way
  task automatic host_write(input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    #1;
    cmd = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
    @(posedge mclk);
    #1;
    cmd.wr = 1'b0;
    cmd.data = ~data;  // Released word shows no stale value
  endtask
  // Read word; answer held during the cycle after the request
  task automatic host_read(input logic [7:0] code, output logic [15:0] data, output logic hit);
    @(posedge mclk);
    #1;
    cmd.rd = 1'b1;
    cmd.code = code;
    @(posedge mclk);
    #1;
    cmd.rd = 1'b0;
    data = rd_data_ff;
    hit = rd_ack_ff ? rd_hit_ff : 1'bx;  // No ack gives an unknown hit
  endtask
  // One-cycle operation request
  task automatic host_op(input omc_pkg::omc_sel_t sel);
    @(posedge mclk);
    #1;
    op = '{strobe: 1'b1, sel: sel};
    @(posedge mclk);
    #1;
    op.strobe = 1'b0;
  endtask
endmodule

// ==== tb/omc_margin_regs_test.sv ====
// Self-checking bench for the margin register bank.
// Assumes the host model drives commands; the bench drives trim.
`timescale 1ns/10ps
module omc_margin_regs_test;
  logic              mclk;                   // Core clock
  logic              rst_n;                  // Reset, active low
  logic       [15:0] trim;                   // Live trim word
  omc_pkg::omc_cmd_t cmd;                    // Command word
  omc_pkg::omc_op_t  op;                     // Operation request
  logic       [15:0] rd_data;                // Read data
  logic              rd_ack, rd_hit;         // Read answer
  logic       [16:0] vout;                   // Commanded output
  logic              active, ivd, c_hi, c_lo; // Status outputs
  int                num_errors = 0;         // Mismatches
  int                n_tests = 0;            // Comparisons
  omc_margin_regs u_dut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .rd_data_ff(rd_data),
    .rd_ack_ff(rd_ack), .rd_hit_ff(rd_hit), .op(op), .trim(trim), .vout_cmd_ff(vout),
    .margin_active_ff(active), .ivd_pulse_ff(ivd), .clamp_high_ff(c_hi), .clamp_low_ff(c_lo));
  omc_host_model u_host (.mclk(mclk), .rd_data_ff(rd_data), .rd_ack_ff(rd_ack),
    .rd_hit_ff(rd_hit), .cmd(cmd), .op(op));
  // Clock, 40 ns period
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Read and compare data and hit
  task automatic rchk(input logic [7:0] code, input logic [15:0] exp, input logic eh);
    logic [15:0] d;
    logic        h;
    u_host.host_read(code, d, h);
    chk("read data", {1'b0, exp}, {1'b0, d});
    chk("read hit", {16'h0000, eh}, {16'h0000, h});
  endtask
  // Request a state; flags are {active, ivd, clamp high, clamp low}
  task automatic ochk(input omc_pkg::omc_sel_t sel, input logic [16:0] ev, input logic [3:0] ef);
    u_host.host_op(sel);
    @(posedge mclk);
    #1;
    chk("vout", ev, vout);
    chk("flags", {13'h0000, ef}, {13'h0000, active, ivd, c_hi, c_lo});
  endtask
  // Verdict and end of run
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    trim = 16'h0000;
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rchk(8'h25, 16'h0547, 1'b1);
    rchk(8'h26, 16'h0451, 1'b1);
    rchk(8'h29, 16'hB900, 1'b1);
    rchk(8'h20, 16'h0016, 1'b1);
    rchk(8'h30, 16'h0000, 1'b0);
    $display("Test reset values done");
    ochk(omc_pkg::OMC_SEL_HIGH, 17'h00547, 4'h8);
    trim = 16'h000A;
    ochk(omc_pkg::OMC_SEL_LOW, 17'h0045B, 4'h8);
    u_host.host_write(8'h25, 16'hFFFF);
    u_host.host_write(8'h26, 16'h0100);
    rchk(8'h25, 16'h7FFF, 1'b1);
    ochk(omc_pkg::OMC_SEL_HIGH, 17'h0060A, 4'hE);
    ochk(omc_pkg::OMC_SEL_LOW, 17'h003A3, 4'hD);
    u_host.host_write(8'h25, 16'h05FA);
    trim = 16'h0064;
    ochk(omc_pkg::OMC_SEL_HIGH, 17'h0065E, 4'h8);
    $display("Test range check done");
    u_host.host_write(8'h29, 16'h0300);
    rchk(8'h29, 16'hBA00, 1'b1);
    ochk(omc_pkg::OMC_SEL_HIGH, 17'h00364, 4'hE);
    ochk(omc_pkg::OMC_SEL_NOMINAL, 17'h00364, 4'h0);
    u_host.host_write(8'h29, 16'h0100);
    ochk(omc_pkg::OMC_SEL_HIGH, 17'h0065E, 4'h8);
    $display("Test scale done");
    u_host.host_write(8'h11, 16'h0000);
    u_host.host_write(8'h25, 16'h0600);
    u_host.host_write(8'h12, 16'h0000);
    rchk(8'h25, 16'h05FA, 1'b1);
    rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    u_host.host_write(8'h26, 16'h0400);
    u_host.host_write(8'h12, 16'h0000);
    rchk(8'h26, 16'h0451, 1'b1);
    u_host.host_write(8'h26, 16'h0400);
    u_host.host_write(8'h13, 16'h0026);
    u_host.host_write(8'h26, 16'h0123);
    u_host.host_write(8'h25, 16'h0111);
    u_host.host_write(8'h14, 16'h0026);
    rchk(8'h26, 16'h0400, 1'b1);
    rchk(8'h25, 16'h0111, 1'b1);
    u_host.host_write(8'h29, 16'h0000);
    rchk(8'h29, 16'hB801, 1'b1);
    u_host.host_write(8'h14, 16'h0029);
    rchk(8'h29, 16'hB900, 1'b1);
    $display("Test store and restore done");
    end_sim();
  end
endmodule
